// ---- core/ssp_cfg.svh ----
// Constants of the flash self-programming sequencer: field positions, sizes, timing.
// Assumes a 10 MHz system clock; included by bare name by the sequencer and core-end design files.
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// Control/status register bit positions
`define SSP_CSR_ENABLE      0
`define SSP_CSR_ERASE       1
`define SSP_CSR_WRITE       2
`define SSP_CSR_LOCKSET     3
`define SSP_CSR_REENABLE    4
`define SSP_CSR_BUSY        6
`define SSP_CSR_IRQ_EN      7

// Command field (bits 4..1) codes
`define SSP_CMD_LOAD        4'h0
`define SSP_CMD_ERASE       4'h1
`define SSP_CMD_WRITE       4'h2
`define SSP_CMD_LOCK        4'h4

// Pointer layout: bit 0 byte select, word in page, page index
`define SSP_WORD_LSB        1
`define SSP_WORD_MSB        6
`define SSP_PAGE_LSB        7
`define SSP_PAGE_MSB        14
`define SSP_WORD_W          6
`define SSP_PAGE_W          8
`define SSP_PAGE_WORDS      64
`define SSP_FLASH_WORDS     16384
`define SSP_FLASH_AW        14
`define SSP_HALTING_SECTION_FIRST_PAGE 8'hE0

// Reset vectors
`define SSP_APP_RESET_ADDR  16'h0000
`define SSP_BOOT_RESET_ADDR 16'h3800

// Reset and read values
`define SSP_LOCK_RESET      8'hFF
`define SSP_ERASED_WORD     16'hFFFF
`define SSP_BLOCKED_BYTE    8'hFF

// Arm window after a command write, in cycles
`define SSP_ARM_WINDOW      3'h4

// Programming time, min and max, and derived cycle counts
`define SSP_CLK_PERIOD_NS   100
`define SSP_PROG_MIN_NS     3700000
`define SSP_PROG_MAX_NS     4500000
`define SSP_PROG_MIN_CYC    ((`SSP_PROG_MIN_NS + `SSP_CLK_PERIOD_NS - 1) / `SSP_CLK_PERIOD_NS)
`define SSP_PROG_MAX_CYC    (`SSP_PROG_MAX_NS / `SSP_CLK_PERIOD_NS)
`define SSP_TIMER_W         16

`endif

// ---- core/ssp_pkg.sv ----
// Types shared by both ends of the flash self-programming sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package ssp_pkg;
  // Sequencer states
  typedef enum logic [0:0] {ST_IDLE, ST_PROG} ssp_state_t;
  // Timed operations
  typedef enum logic [1:0] {OP_ERASE, OP_WRITE, OP_LOCK} ssp_op_t;
  // Core-side request kinds
  typedef enum logic [2:0] {KIND_STORE, KIND_CSR, KIND_SPM, KIND_LOAD, KIND_EEPROM} ssp_kind_t;
  // Core-side sequencing
  typedef enum logic [0:0] {H_IDLE, H_SPM} ssp_host_state_t;
endpackage

// ---- core/ssp_if.sv ----
// Link between the CPU core and the self-programming sequencer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
`default_nettype none
interface ssp_if;
  logic        csr_wr;      // Control register write strobe
  logic [7:0]  csr_wdata;
  logic [7:0]  csr_rdata;   // Live control/status value
  logic        spm;         // Store-program instruction strobe
  logic [15:0] z;           // Pointer pair, high byte and low byte
  logic [15:0] r10;         // Data word, high and low register
  logic        lpm;         // Load-program read strobe
  logic [7:0]  lpm_data;
  logic        lpm_valid;
  logic        ee_wr;       // EEPROM write event
  logic        halt;
  logic        irq;
  logic [15:0] rst_vec;
  logic        rww_blocked;

  modport dev (input csr_wr, csr_wdata, spm, z, r10, lpm, ee_wr,
               output csr_rdata, lpm_data, lpm_valid, halt, irq, rst_vec, rww_blocked);
  modport cpu (output csr_wr, csr_wdata, spm, z, r10, lpm, ee_wr,
               input csr_rdata, lpm_data, lpm_valid, halt, irq, rst_vec, rww_blocked);
endinterface
`default_nettype wire

// ---- core/ssp_seq_dev.sv ----
// Flash self-programming sequencer: control register, page buffer, flash array, timer.
// Assumes the CPU core drives the link from flops on the same clock.
//
// Notes on behaviour
// - Fuse selects application or loader reset vector
// - Fuse reaches only from external pin
// - Pointer low bits word, high bits page
// - Target address latched when operation starts
// - Lock-bit setting ignores pointer entirely
// - Reads bytewise, pointer bit zero picks byte
// - Erase command plus store within four cycles
// - Halting section programming halts CPU
// - Buffer load command plus store within four
// - Buffer cleared on write, reenable, reset
// - Each buffer location written once only; here a second load overwrites
// - EEPROM write discards loaded buffer data
// - Write command, page only in pointer
// - Interrupt held while enable bit clear
// - Concurrent section blocked, busy flag set
// - Software clears busy via reenable bit
// - Erase before write; buffer fill either order
// - Buffer loads accepted in any order
// - Same page index for erase, write
// - Vectors moved or interrupts off meanwhile
// - Lock loader write bit if unchanging
// - Armed bits auto-clear without store
// - Each timed operation 3.7 to 4.5 ms
`include "ssp_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module ssp_seq_dev #(
  parameter int unsigned PROG_CYCLES = `SSP_PROG_MIN_CYC
) (
  input  wire logic       SYS_CLK,
  input  wire logic       RST_N,
  input  wire logic       BOOT_RESET_SEL_FUSE,
  ssp_if.dev              BUS,
  output logic [7:0]      LOCK_BITS,
  output logic            OP_ACTIVE
);

  logic                      fuse_s1_ff;
  logic                      fuse_s2_ff;
  logic [15:0]               vec_ff;
  logic                      enable_ff;
  logic [3:0]                cmd_ff;
  logic                      irq_en_ff;
  logic                      busy_ff;
  logic [2:0]                arm_ff;
  ssp_pkg::ssp_state_t       state_ff;
  ssp_pkg::ssp_op_t          op_ff;
  logic [`SSP_TIMER_W-1:0]   timer_ff;
  logic [`SSP_PAGE_W-1:0]    page_ff;
  logic [5:0]                lock_r0_ff;
  logic                      halt_ff;
  logic [7:0]                lock_ff;
  logic [7:0]                rd_byte_ff;
  logic                      rd_valid_ff;
  logic [15:0]               buf_mem [`SSP_PAGE_WORDS];
  logic [`SSP_PAGE_WORDS-1:0] buf_vld_ff;
  logic [15:0]               flash_mem [`SSP_FLASH_WORDS];

  logic                      idle;
  logic                      armed;
  logic                      start;
  logic                      done;
  logic                      timeout;
  logic                      csr_take;
  logic                      reenable_wr;
  logic                      buf_clear;
  logic [`SSP_WORD_W-1:0]    word_idx;
  logic [`SSP_PAGE_W-1:0]    page_idx;
  logic [`SSP_FLASH_AW-1:0]  rd_word;
  logic [15:0]               rd_word_val;

  // Pointer split into word and page fields
  assign word_idx    = BUS.z[`SSP_WORD_MSB:`SSP_WORD_LSB];
  assign page_idx    = BUS.z[`SSP_PAGE_MSB:`SSP_PAGE_LSB];
  assign idle        = (state_ff == ssp_pkg::ST_IDLE);
  assign armed       = (arm_ff != 3'h0);
  assign start       = BUS.spm & armed & idle;
  assign done        = (state_ff == ssp_pkg::ST_PROG) && (timer_ff == '0);
  assign timeout     = (arm_ff == 3'h1) & ~BUS.spm;
  assign csr_take    = BUS.csr_wr & idle;
  assign reenable_wr = csr_take & BUS.csr_wdata[`SSP_CSR_ENABLE]
                       & BUS.csr_wdata[`SSP_CSR_REENABLE];

  // Fuse is a pin: two flops, and no path from the core can change it
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      fuse_s1_ff <= 1'b1;
      fuse_s2_ff <= 1'b1;
    end else begin
      fuse_s1_ff <= BOOT_RESET_SEL_FUSE;
      fuse_s2_ff <= fuse_s1_ff;
    end
  end

  // Reset vector: unprogrammed fuse picks application start
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      vec_ff <= `SSP_APP_RESET_ADDR;
    end else begin
      vec_ff <= fuse_s2_ff ? `SSP_APP_RESET_ADDR : `SSP_BOOT_RESET_ADDR;
    end
  end

  // Arm window: store must follow a command write within four cycles
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      arm_ff <= 3'h0;
    end else if (csr_take) begin
      arm_ff <= (BUS.csr_wdata[`SSP_CSR_ENABLE] && !reenable_wr) ? `SSP_ARM_WINDOW : 3'h0;
    end else if (BUS.spm) begin
      arm_ff <= 3'h0;
    end else if (armed) begin
      arm_ff <= arm_ff - 3'h1;
    end
  end

  // Control bits; completion wins over a late write since enable and command writes need idle
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      enable_ff <= 1'b0;
      cmd_ff    <= 4'h0;
      irq_en_ff <= 1'b0;
    end else begin
      if (BUS.csr_wr) begin
        irq_en_ff <= BUS.csr_wdata[`SSP_CSR_IRQ_EN];
      end
      if (done) begin
        enable_ff <= 1'b0;
        cmd_ff    <= 4'h0;
      end else if (start) begin
        if (cmd_ff != `SSP_CMD_ERASE && cmd_ff != `SSP_CMD_WRITE && cmd_ff != `SSP_CMD_LOCK) begin
          enable_ff <= 1'b0; // Load ends at once; odd codes are dropped
          cmd_ff    <= 4'h0;
        end
      end else if (csr_take) begin
        // Reenable acts at the write itself and never arms
        enable_ff <= BUS.csr_wdata[`SSP_CSR_ENABLE] & ~reenable_wr;
        cmd_ff    <= BUS.csr_wdata[`SSP_CSR_ENABLE] ? BUS.csr_wdata[4:1] : 4'h0;
      end else if (timeout) begin
        enable_ff <= 1'b0;
        cmd_ff    <= 4'h0;
      end
    end
  end

  // Sequencer: latch target, time the operation
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff   <= ssp_pkg::ST_IDLE;
      op_ff      <= ssp_pkg::OP_ERASE;
      timer_ff   <= '0;
      page_ff    <= '0;
      lock_r0_ff <= 6'h00;
      halt_ff    <= 1'b0;
    end else begin
      case (state_ff)
        ssp_pkg::ST_IDLE: begin
          if (start && (cmd_ff == `SSP_CMD_ERASE || cmd_ff == `SSP_CMD_WRITE)) begin
            state_ff <= ssp_pkg::ST_PROG;
            op_ff    <= (cmd_ff == `SSP_CMD_ERASE) ? ssp_pkg::OP_ERASE : ssp_pkg::OP_WRITE;
            page_ff  <= page_idx;
            timer_ff <= `SSP_TIMER_W'(PROG_CYCLES - 1);
            halt_ff  <= (page_idx >= `SSP_HALTING_SECTION_FIRST_PAGE);
          end else if (start && cmd_ff == `SSP_CMD_LOCK) begin
            state_ff   <= ssp_pkg::ST_PROG;
            op_ff      <= ssp_pkg::OP_LOCK;
            lock_r0_ff <= BUS.r10[5:0]; // Pointer not looked at
            timer_ff   <= `SSP_TIMER_W'(PROG_CYCLES - 1);
          end
        end
        ssp_pkg::ST_PROG: begin
          if (done) begin
            state_ff <= ssp_pkg::ST_IDLE;
            halt_ff  <= 1'b0;
          end else begin
            timer_ff <= timer_ff - `SSP_TIMER_W'(1);
          end
        end
        default: begin
          state_ff <= ssp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Busy flag: set by any erase or write, cleared only by reenable
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      busy_ff <= 1'b0;
    end else if (start && (cmd_ff == `SSP_CMD_ERASE || cmd_ff == `SSP_CMD_WRITE)) begin
      busy_ff <= 1'b1;
    end else if (reenable_wr) begin
      busy_ff <= 1'b0;
    end
  end

  // Buffer clear beats a load in the same cycle, so an EEPROM write drops all
  assign buf_clear = (done && op_ff == ssp_pkg::OP_WRITE) || reenable_wr
                     || BUS.ee_wr;

  // Page buffer valid bits; reset empties the buffer
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      buf_vld_ff <= '0;
    end else if (buf_clear) begin
      buf_vld_ff <= '0;
    end else if (start && cmd_ff == `SSP_CMD_LOAD) begin
      buf_vld_ff[word_idx] <= 1'b1; // Any word order
    end
  end

  // Page buffer data; a second load to one slot simply overwrites
  always_ff @(posedge SYS_CLK) begin
    if (start && cmd_ff == `SSP_CMD_LOAD) begin
      buf_mem[word_idx] <= BUS.r10;
    end
  end

  // Flash array changes only at the end of a timed operation
  always_ff @(posedge SYS_CLK) begin
    if (done && op_ff == ssp_pkg::OP_ERASE) begin
      for (int i = 0; i < `SSP_PAGE_WORDS; i++) begin
        flash_mem[{page_ff, `SSP_WORD_W'(i)}] <= `SSP_ERASED_WORD;
      end
    end else if (done && op_ff == ssp_pkg::OP_WRITE) begin
      // Programming only clears bits; empty slots leave the word alone
      for (int i = 0; i < `SSP_PAGE_WORDS; i++) begin
        if (buf_vld_ff[i]) begin
          flash_mem[{page_ff, `SSP_WORD_W'(i)}] <=
            flash_mem[{page_ff, `SSP_WORD_W'(i)}] & buf_mem[i];
        end
      end
    end
  end

  // Lock bits: a zero in data bits 5..0 programs the bit, never unprograms
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lock_ff <= `SSP_LOCK_RESET;
    end else if (done && op_ff == ssp_pkg::OP_LOCK) begin
      lock_ff <= lock_ff & {2'b11, lock_r0_ff};
    end
  end

  // Bytewise read; concurrent section reads blocked while busy
  assign rd_word     = BUS.z[`SSP_PAGE_MSB:`SSP_WORD_LSB];
  assign rd_word_val = flash_mem[rd_word];
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_byte_ff  <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= BUS.lpm;
      if (BUS.lpm) begin
        if (busy_ff && page_idx < `SSP_HALTING_SECTION_FIRST_PAGE) begin
          rd_byte_ff <= `SSP_BLOCKED_BYTE;
        end else begin
          rd_byte_ff <= BUS.z[0] ? rd_word_val[15:8] : rd_word_val[7:0];
        end
      end
    end
  end

  // Status view and link outputs
  assign BUS.csr_rdata   = {irq_en_ff, busy_ff, 1'b0, cmd_ff, enable_ff};
  assign BUS.irq         = irq_en_ff & ~enable_ff; // Level, not a pulse
  assign BUS.halt        = halt_ff;
  assign BUS.rww_blocked = busy_ff;
  assign BUS.lpm_data    = rd_byte_ff;
  assign BUS.lpm_valid   = rd_valid_ff;
  assign BUS.rst_vec     = vec_ff;
  assign LOCK_BITS       = lock_ff;
  assign OP_ACTIVE       = ~idle;

endmodule
`default_nettype wire

// ---- core/ssp_cpu_host.sv ----
// CPU-core end of the self-programming link: turns requests into strobes.
// Assumes the sequencer on the far side of the interface, same clock.
`include "ssp_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module ssp_cpu_host (
  input  wire logic              SYS_CLK,
  input  wire logic              RST_N,
  input  wire logic              REQ_VALID,
  input  wire ssp_pkg::ssp_kind_t REQ_KIND,
  input  wire logic [7:0]        REQ_CSR,
  input  wire logic [15:0]       REQ_Z,
  input  wire logic [15:0]       REQ_DATA,
  output logic                   REQ_READY,
  output logic                   REQ_REFUSED,
  output logic [7:0]             RD_DATA,
  output logic                   RD_VALID,
  output logic [7:0]             CSR_STATUS,
  output logic                   SPM_IRQ,
  output logic                   CPU_HALTED,
  output logic [15:0]            RESET_VECTOR,
  ssp_if.cpu                     BUS
);

  ssp_pkg::ssp_host_state_t state_ff;
  logic                     csr_wr_ff;
  logic [7:0]               csr_wdata_ff;
  logic                     spm_ff;
  logic [15:0]              z_ff;
  logic [15:0]              r10_ff;
  logic                     lpm_ff;
  logic                     ee_ff;
  logic                     refused_ff;
  logic                     take;
  logic                     rww_target;
  logic [15:0]              page_only;

  // Halted core takes nothing new
  assign REQ_READY  = (state_ff == ssp_pkg::H_IDLE) & ~BUS.halt;
  assign take       = REQ_VALID & REQ_READY;
  assign rww_target = (REQ_Z[`SSP_PAGE_MSB:`SSP_PAGE_LSB] < `SSP_HALTING_SECTION_FIRST_PAGE);
  // Erase and write carry the page index with every other pointer bit zero
  assign page_only  = {1'b0, REQ_Z[`SSP_PAGE_MSB:`SSP_PAGE_LSB], 7'h00};

  // Request sequencing; a store puts the instruction one cycle after the write
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff     <= ssp_pkg::H_IDLE;
      csr_wr_ff    <= 1'b0;
      csr_wdata_ff <= 8'h00;
      spm_ff       <= 1'b0;
      z_ff         <= 16'h0000;
      r10_ff       <= 16'h0000;
      lpm_ff       <= 1'b0;
      ee_ff        <= 1'b0;
      refused_ff   <= 1'b0;
    end else begin
      csr_wr_ff  <= 1'b0;
      spm_ff     <= 1'b0;
      lpm_ff     <= 1'b0;
      ee_ff      <= 1'b0;
      refused_ff <= 1'b0;
      case (state_ff)
        ssp_pkg::H_IDLE: begin
          if (take) begin
            r10_ff <= REQ_DATA;
            z_ff   <= REQ_Z;
            case (REQ_KIND)
              ssp_pkg::KIND_STORE: begin
                csr_wr_ff    <= 1'b1;
                csr_wdata_ff <= REQ_CSR;
                if (REQ_CSR[`SSP_CSR_ERASE] || REQ_CSR[`SSP_CSR_WRITE]) begin
                  z_ff <= page_only;
                end
                state_ff <= ssp_pkg::H_SPM;
              end
              ssp_pkg::KIND_CSR: begin
                csr_wr_ff    <= 1'b1;
                csr_wdata_ff <= REQ_CSR;
              end
              ssp_pkg::KIND_SPM: begin
                spm_ff <= 1'b1;
              end
              ssp_pkg::KIND_LOAD: begin
                // No concurrent-section read until busy is cleared
                if (rww_target && BUS.rww_blocked) begin
                  refused_ff <= 1'b1;
                end else begin
                  lpm_ff <= 1'b1;
                end
              end
              ssp_pkg::KIND_EEPROM: begin
                ee_ff <= 1'b1;
              end
              default: begin
                refused_ff <= 1'b1;
              end
            endcase
          end
        end
        ssp_pkg::H_SPM: begin
          spm_ff   <= 1'b1; // Second cycle, well inside the window
          state_ff <= ssp_pkg::H_IDLE;
        end
        default: begin
          state_ff <= ssp_pkg::H_IDLE;
        end
      endcase
    end
  end

  assign BUS.csr_wr    = csr_wr_ff;
  assign BUS.csr_wdata = csr_wdata_ff;
  assign BUS.spm       = spm_ff;
  assign BUS.z         = z_ff;
  assign BUS.r10       = r10_ff;
  assign BUS.lpm       = lpm_ff;
  assign BUS.ee_wr     = ee_ff;
  assign REQ_REFUSED   = refused_ff;
  assign RD_DATA       = BUS.lpm_data;
  assign RD_VALID      = BUS.lpm_valid;
  assign CSR_STATUS    = BUS.csr_rdata;
  assign SPM_IRQ       = BUS.irq;
  assign CPU_HALTED    = BUS.halt;
  assign RESET_VECTOR  = BUS.rst_vec;

endmodule
`default_nettype wire

// ---- bench/ssp_properties.sv ----
// Link checker: arming window, timed operations, busy flag, halt, interrupt.
// Assumes the bench places it beside the link, on the system clock and reset.
`timescale 1ns/1ns
`default_nettype none
module ssp_properties #(
  parameter int PROG_CYCLES = 20
) (
  input wire logic        SYS_CLK,
  input wire logic        RST_N,
  input wire logic        csr_wr,
  input wire logic [7:0]  csr_wdata,
  input wire logic [7:0]  csr_rdata,
  input wire logic        spm,
  input wire logic [15:0] z,
  input wire logic        lpm,
  input wire logic        lpm_valid,
  input wire logic        halt,
  input wire logic        irq
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  // Halt length counter; a long repetition would be too slow to unroll
  logic [15:0] halt_cnt_ff;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) halt_cnt_ff <= 16'h0000;
    else if (halt) halt_cnt_ff <= halt_cnt_ff + 16'h0001;
    else halt_cnt_ff <= 16'h0000;
  end

  // Command write that arms the store strobe
  sequence s_arm;
    csr_wr && csr_wdata[0] && !csr_wdata[4];
  endsequence
  // Erase or write command followed at once by the store strobe
  sequence s_timed;
    csr_wr && (csr_wdata[4:0] == 5'h03 || csr_wdata[4:0] == 5'h05) ##1 spm;
  endsequence
  // Buffer-load command followed at once by the store strobe
  sequence s_load;
    csr_wr && csr_wdata[4:0] == 5'h01 ##1 spm;
  endsequence

  // Relations between the link signals
  a_irq_follows: assert property (irq == (csr_rdata[7] && !csr_rdata[0]))
    else $error("irq level disagrees with mask and enable");
  a_arm_expires: assert property (s_arm ##1 !spm [*4] |=> !csr_rdata[0])
    else $error("enable bit survived an unused arm window");
  a_load_done: assert property (s_load |=> !csr_rdata[0])
    else $error("enable bit not cleared after buffer load");
  a_busy_on: assert property (s_timed |=> csr_rdata[6])
    else $error("busy flag not set at operation start");
  a_busy_holds: assert property (csr_rdata[6] && !(csr_wr && csr_wdata[4] && csr_wdata[0])
    |=> csr_rdata[6])
    else $error("busy flag dropped without reenable");
  a_reenable_clr: assert property (csr_wr && csr_wdata[4] && csr_wdata[0] && !halt
    |=> !csr_rdata[6] && !csr_rdata[0])
    else $error("reenable write left busy or enable set");
  a_halt_page: assert property (s_timed |=> halt == ($past(z[14:7]) >= 8'hE0))
    else $error("halt does not match target section");
  a_halt_length: assert property ($fell(halt) |-> halt_cnt_ff == 16'(PROG_CYCLES))
    else $error("halt length differs from programming time");
  a_read_answer: assert property (lpm_valid == $past(lpm))
    else $error("read answer not one cycle after strobe");
endmodule
`default_nettype wire

// ---- bench/ssp_tb_top.sv ----
// Bench: core end and sequencer end joined by the link, driven at the core's request port.
// Assumes a 10 MHz clock and a programming time shortened to 20 cycles.
`timescale 1ns/1ns
`default_nettype none
module ssp_tb_top;
  localparam int PROG = 20;
  logic               sys_clk;
  logic               rst_n;
  logic               fuse;
  logic               req_valid;
  ssp_pkg::ssp_kind_t req_kind;
  logic [7:0]         req_csr;
  logic [15:0]        req_z;
  logic [15:0]        req_data;
  logic               req_ready;
  logic               req_refused;
  logic [7:0]         rd_data;
  logic               rd_valid;
  logic [7:0]         csr_status;
  logic               spm_irq;
  logic               cpu_halted;
  logic [15:0]        reset_vector;
  logic [7:0]         lock_bits;
  logic               op_active;
  logic [5:0]         row_word [4];
  logic [15:0]        row_data [4];
  int                 errors;
  int                 checks;
  int                 cycles;

  ssp_if bus ();
  ssp_seq_dev #(.PROG_CYCLES(PROG)) u_ssp_seq_dev (.SYS_CLK(sys_clk), .RST_N(rst_n),
    .BOOT_RESET_SEL_FUSE(fuse), .BUS(bus.dev), .LOCK_BITS(lock_bits), .OP_ACTIVE(op_active));
  ssp_cpu_host u_ssp_cpu_host (.SYS_CLK(sys_clk), .RST_N(rst_n), .REQ_VALID(req_valid),
    .REQ_KIND(req_kind), .REQ_CSR(req_csr), .REQ_Z(req_z), .REQ_DATA(req_data),
    .REQ_READY(req_ready), .REQ_REFUSED(req_refused), .RD_DATA(rd_data), .RD_VALID(rd_valid),
    .CSR_STATUS(csr_status), .SPM_IRQ(spm_irq), .CPU_HALTED(cpu_halted),
    .RESET_VECTOR(reset_vector), .BUS(bus.cpu));
  ssp_properties #(.PROG_CYCLES(PROG)) u_ssp_properties (.SYS_CLK(sys_clk), .RST_N(rst_n),
    .csr_wr(bus.csr_wr), .csr_wdata(bus.csr_wdata), .csr_rdata(bus.csr_rdata), .spm(bus.spm),
    .z(bus.z), .lpm(bus.lpm), .lpm_valid(bus.lpm_valid), .halt(bus.halt), .irq(bus.irq));

  // Free-running system clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One request, held until the core end takes it
  task automatic req(input ssp_pkg::ssp_kind_t k, input logic [7:0] c, input logic [15:0] zz,
                     input logic [15:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_kind  <= k;
    req_csr   <= c;
    req_z     <= zz;
    req_data  <= d;
    @(posedge sys_clk);
    while (req_ready !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    if (req_ready !== 1'b1) errors++;
    req_valid <= 1'b0;
  endtask

  // Waits out a timed operation; the start shows two edges after the take
  task automatic op_wait();
    int n;
    n = 0;
    repeat (3) @(posedge sys_clk);
    while (op_active === 1'b1 && n < 2 * PROG) begin
      @(posedge sys_clk);
      n++;
    end
    if (op_active === 1'b1) errors++;
  endtask

  task automatic op(input logic [7:0] c, input logic [15:0] zz, input logic [15:0] d);
    req(ssp_pkg::KIND_STORE, c, zz, d);
    if (c[3:1] != 3'h0) op_wait();
  endtask

  task automatic reen();
    req(ssp_pkg::KIND_CSR, 8'h11, 16'h0000, 16'h0000);
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic rd(input logic [15:0] zz, input logic [7:0] exp);
    int n;
    n = 0;
    req(ssp_pkg::KIND_LOAD, 8'h00, zz, 16'h0000);
    @(posedge sys_clk);
    while (rd_valid !== 1'b1 && n < 4) begin
      @(posedge sys_clk);
      n++;
    end
    chk1("read valid", 1'b1, rd_valid);
    chk16("read byte", {8'h00, exp}, {8'h00, rd_data});
  endtask

  task automatic refused(input logic [15:0] zz);
    req(ssp_pkg::KIND_LOAD, 8'h00, zz, 16'h0000);
    @(posedge sys_clk);
    chk1("busy read refused", 1'b1, req_refused);
  endtask

  initial begin
    errors = 0;
    checks = 0;
    cycles = 0;
    rst_n = 1'b0;
    fuse = 1'b1;
    req_valid = 1'b0;
    req_kind = ssp_pkg::KIND_CSR;
    req_csr = 8'h00;
    req_z = 16'h0000;
    req_data = 16'h0000;
    row_word = '{6'h3F, 6'h00, 6'h11, 6'h01};
    row_data = '{16'h1234, 16'hABCD, 16'h00FF, 16'h8001};
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk16("status after reset", 16'h0000, {8'h00, csr_status});
    chk1("irq after reset", 1'b0, spm_irq);
    chk16("application vector", 16'h0000, reset_vector);
    // Rows: page 5 erased, loaded out of order, written, read back bytewise
    op(8'h03, 16'h0280, 16'hFFFF);
    chk1("busy after erase", 1'b1, csr_status[6]);
    refused(16'h0280);
    for (int i = 0; i < 4; i++) begin
      op(8'h01, {1'b0, 8'h05, row_word[i], 1'b0}, row_data[i]);
    end
    op(8'h05, 16'h0280, 16'h0000);
    reen();
    chk1("busy after reenable", 1'b0, csr_status[6]);
    for (int i = 0; i < 4; i++) begin
      rd({1'b0, 8'h05, row_word[i], 1'b0}, row_data[i][7:0]);
      rd({1'b0, 8'h05, row_word[i], 1'b1}, row_data[i][15:8]);
    end
    rd(16'h0284, 8'hFF);
    // Buffer discarded by reenable and by an EEPROM write
    op(8'h01, 16'h0304, 16'h0000);
    op(8'h03, 16'h0300, 16'h0000);
    reen();
    op(8'h01, 16'h0300, 16'h0000);
    req(ssp_pkg::KIND_EEPROM, 8'h00, 16'h0000, 16'h0000);
    op(8'h01, 16'h0302, 16'hA5C3);
    op(8'h05, 16'h0300, 16'h0000);
    reen();
    rd(16'h0304, 8'hFF);
    rd(16'h0300, 8'hFF);
    rd(16'h0303, 8'hA5);
    // Erase in the halting section stops the core
    req(ssp_pkg::KIND_STORE, 8'h03, 16'h7080, 16'h0000);
    repeat (4) @(posedge sys_clk);
    chk1("core halted", 1'b1, cpu_halted);
    op_wait();
    reen();
    chk1("core released", 1'b0, cpu_halted);
    // Pointer moved during an erase of page 7; halting section stays readable
    req(ssp_pkg::KIND_STORE, 8'h03, 16'h0380, 16'h0000);
    repeat (2) @(posedge sys_clk); // Busy rises only with the store
    refused(16'h0282);
    rd(16'h7081, 8'hFF);
    op_wait();
    reen();
    rd(16'h0380, 8'hFF);
    rd(16'h0281, 8'hAB);
    // Arm window runs out; interrupt follows the enable bit
    req(ssp_pkg::KIND_CSR, 8'h81, 16'h0000, 16'h0000);
    repeat (3) @(posedge sys_clk);
    chk1("armed", 1'b1, csr_status[0]);
    chk1("irq while armed", 1'b0, spm_irq);
    repeat (4) @(posedge sys_clk);
    chk1("arm expired", 1'b0, csr_status[0]);
    chk1("irq raised", 1'b1, spm_irq);
    req(ssp_pkg::KIND_SPM, 8'h00, 16'h0280, 16'h0000);
    repeat (3) @(posedge sys_clk);
    chk1("stray store idle", 1'b0, op_active);
    req(ssp_pkg::KIND_CSR, 8'h00, 16'h0000, 16'h0000);
    repeat (3) @(posedge sys_clk);
    chk1("irq masked", 1'b0, spm_irq);
    // Lock setting with a pointer that must not matter
    op(8'h09, 16'hBEEF, 16'h00F0);
    chk16("lock bits", 16'h00F0, {8'h00, lock_bits});
    // Reset mid-run: loader vector, buffer emptied
    fuse <= 1'b0;
    op(8'h01, 16'h0286, 16'h0000);
    repeat (3) @(posedge sys_clk); // Let the load land first
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk16("loader vector", 16'h3800, reset_vector);
    op(8'h05, 16'h0280, 16'h0000);
    reen();
    rd(16'h0286, 8'hFF);
    summarize();
  end
endmodule
`default_nettype wire
